/* File: hdl/flash_cmd_pkg.sv */
// Constants, opcodes and carrier types for the serial flash command front end
// Functional notes
// - Opcode, address and data bytes travel most-significant bit first.
// - An unsupported opcode starts no operation.
// - After an unsupported opcode, input is ignored until chip select cycles.
// - Release before opcode and address complete performs nothing, back to idle.
// - Addressed commands take exactly three address bytes, bits 23 down to 0.
// - Upper six address bits are ignored; 18 bits select a byte.
// - Read 0Bh takes one dummy byte, read 03h takes none.
// - After address and dummies, array data leaves on each clock, MSB first.
// - Read address counter steps forward automatically while clocking continues.
// - After 03FFFFh the read continues at 000000h without delay.
// - Chip select release at any bit ends a read, output goes high impedance.
// - Block erase codes 20h, 52h, D8h take three address bytes.
// - Chip erase codes 60h and C7h take no address or data.
// - Program 02h takes three address bytes and 1 to 256 data bytes.
// - Lock 36h, unlock 39h, lock read 3Ch take address; 3Ch returns data.
// - OTP write 9Bh takes address and data; OTP read 77h has two dummies.
// - Identification 9Fh takes no address and returns one to four bytes.
// - B9h enters deep standby, ABh leaves it; no address or data.
// - Modes 0 and 3 only; sample on rising, drive on falling edge.
package flash_cmd_pkg;

  localparam int ADDR_W = 18;
  localparam int BUF_DEPTH = 2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 18'h3FFFF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h00000;
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  localparam logic [7:0] OP_READ_FAST = 8'h0B;
  localparam logic [7:0] OP_READ_SLOW = 8'h03;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_LOCK = 8'h36;
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_LOCK_READ = 8'h3C;
  localparam logic [7:0] OP_OTP_WRITE = 8'h9B;
  localparam logic [7:0] OP_OTP_READ = 8'h77;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_IDENT = 8'h9F;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;

  localparam logic [1:0] DUMMY_NONE = 2'h0;
  localparam logic [1:0] DUMMY_ONE = 2'h1;
  localparam logic [1:0] DUMMY_TWO = 2'h2;

  typedef struct packed {
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
  } op_info_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_OPCODE = 7'h02,
    ST_ADDR = 7'h04,
    ST_DUMMY = 7'h08,
    ST_DATAIN = 7'h10,
    ST_DATAOUT = 7'h20,
    ST_IGNORE = 7'h40
  } state_t;

endpackage

/* File: hdl/pin_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        meta_q[i] <= 1'b1;
        sync_q[i] <= 1'b1;
      end else begin
        meta_q[i] <= din[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign dout = sync_q;
endmodule
`default_nettype wire

/* File: hdl/two_entry_buffer.sv */
// Two-entry valid/ready buffer with flush
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer
  import flash_cmd_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic flush,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady,
  output logic [1:0] level
);
  logic [WIDTH-1:0] mem_q [BUF_DEPTH];
  logic [WIDTH-1:0] mem_d [BUF_DEPTH];
  logic wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d, inReady_q, inReady_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign push = inValid & inReady_q & ~flush;
  assign pop = outReady & (cnt_q != 2'h0) & ~flush;

  always_comb begin
    mem_d = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    cnt_d = cnt_q;
    if (flush) begin
      wrPtr_d = 1'b0;
      rdPtr_d = 1'b0;
      cnt_d = 2'h0;
    end else begin
      if (push) begin
        mem_d[wrPtr_q] = inData;
        wrPtr_d = ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_d = ~rdPtr_q;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end
    inReady_d = (cnt_d != 2'h2);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      cnt_q <= 2'h0;
      inReady_q <= 1'b1;
    end else begin
      mem_q <= mem_d;
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      cnt_q <= cnt_d;
      inReady_q <= inReady_d;
    end
  end

  assign inReady = inReady_q;
  assign outValid = (cnt_q != 2'h0);
  assign outData = mem_q[rdPtr_q];
  assign level = cnt_q;
endmodule
`default_nettype wire

/* File: hdl/serial_flash_cmd_front_end.sv */
// Serial command front end: framing, opcode decode, address, read streaming
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_front_end
  import flash_cmd_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  output logic soData,
  output logic soOeN,
  output logic opValid,
  output op_info_t opInfo,
  output logic opEnd,
  output logic opEndAligned,
  output logic wrValid,
  output logic [7:0] wrByte,
  output logic fetchValid,
  output op_info_t fetchReq,
  input wire logic fetchReady,
  input wire logic arrayValid,
  input wire logic [7:0] arrayData,
  output logic arrayReady
);
  // ****************************************************
  // Pin sampling and edge detection
  // ****************************************************
  logic csHigh, sckS, siS, sckPrev_q, sckRise, sckFall;

  pin_sync #(.WIDTH(3)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .din({csN, sck, si}),
    .dout({csHigh, sckS, siS})
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sckPrev_q <= 1'b1;
    end else begin
      sckPrev_q <= sckS;
    end
  end

  assign sckRise = sckS & ~sckPrev_q & ~csHigh;
  assign sckFall = ~sckS & sckPrev_q & ~csHigh;

  // ****************************************************
  // Opcode decode
  // ****************************************************
  function automatic logic isSupported(input logic [7:0] op);
    case (op)
      OP_READ_FAST, OP_READ_SLOW, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K,
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_PROGRAM, OP_WR_ENABLE,
      OP_WR_DISABLE, OP_LOCK, OP_UNLOCK, OP_LOCK_READ, OP_OTP_WRITE,
      OP_OTP_READ, OP_STATUS_READ, OP_STATUS_WRITE, OP_IDENT, OP_SLEEP,
      OP_WAKE: isSupported = 1'b1;
      default: isSupported = 1'b0;
    endcase
  endfunction

  function automatic logic needsAddr(input logic [7:0] op);
    case (op)
      OP_READ_FAST, OP_READ_SLOW, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K,
      OP_PROGRAM, OP_LOCK, OP_UNLOCK, OP_LOCK_READ, OP_OTP_WRITE,
      OP_OTP_READ: needsAddr = 1'b1;
      default: needsAddr = 1'b0;
    endcase
  endfunction

  function automatic logic isRead(input logic [7:0] op);
    case (op)
      OP_READ_FAST, OP_READ_SLOW, OP_LOCK_READ, OP_OTP_READ, OP_STATUS_READ,
      OP_IDENT: isRead = 1'b1;
      default: isRead = 1'b0;
    endcase
  endfunction

  function automatic logic takesData(input logic [7:0] op);
    case (op)
      OP_PROGRAM, OP_OTP_WRITE, OP_STATUS_WRITE: takesData = 1'b1;
      default: takesData = 1'b0;
    endcase
  endfunction

  function automatic logic [1:0] dummyCount(input logic [7:0] op);
    case (op)
      OP_READ_FAST: dummyCount = DUMMY_ONE;
      OP_OTP_READ: dummyCount = DUMMY_TWO;
      default: dummyCount = DUMMY_NONE;
    endcase
  endfunction

  // ****************************************************
  // Command framing state
  // ****************************************************
  state_t state_q, state_d;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic [1:0] byteCnt_q, byteCnt_d;
  logic [7:0] inShift_q, inShift_d, opcode_q, opcode_d, rxByte;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic started_q, started_d, opValid_q, opValid_d, opEnd_q, opEnd_d;
  logic opEndAligned_q, opEndAligned_d, wrValid_q, wrValid_d;
  logic [7:0] wrByte_q, wrByte_d;
  op_info_t opInfo_q, opInfo_d;

  assign rxByte = {inShift_q[6:0], siS};

  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    byteCnt_d = byteCnt_q;
    inShift_d = inShift_q;
    opcode_d = opcode_q;
    addr_d = addr_q;
    started_d = started_q;
    opValid_d = 1'b0;
    opInfo_d = opInfo_q;
    opEnd_d = 1'b0;
    opEndAligned_d = 1'b0;
    wrValid_d = 1'b0;
    wrByte_d = wrByte_q;
    if (csHigh) begin
      if (state_q != ST_IDLE) begin
        opEnd_d = started_q;
        opEndAligned_d = started_q & (bitCnt_q == 3'h0);
      end
      state_d = ST_IDLE;
      bitCnt_d = 3'h0;
      byteCnt_d = 2'h0;
      started_d = 1'b0;
    end else if (state_q == ST_IDLE) begin
      state_d = ST_OPCODE;
    end else if (sckRise && state_q != ST_IGNORE) begin
      inShift_d = rxByte;
      bitCnt_d = bitCnt_q + 3'h1;
      case (state_q)
        ST_OPCODE: begin
          if (bitCnt_q == BIT_LAST) begin
            opcode_d = rxByte;
            byteCnt_d = 2'h0;
            if (!isSupported(rxByte)) begin
              state_d = ST_IGNORE;
            end else if (needsAddr(rxByte)) begin
              state_d = ST_ADDR;
            end else begin
              opValid_d = 1'b1;
              started_d = 1'b1;
              opInfo_d = '{opcode: rxByte, addr: ADDR_ZERO};
              addr_d = ADDR_ZERO;
              state_d = isRead(rxByte) ? ST_DATAOUT : ST_DATAIN;
            end
          end
        end
        ST_ADDR: begin
          // upper bits fall off the top
          addr_d = {addr_q[ADDR_W-2:0], siS};
          if (bitCnt_q == BIT_LAST) begin
            byteCnt_d = byteCnt_q + 2'h1;
            // third address byte completes the header
            if (byteCnt_q == ADDR_LAST) begin
              opValid_d = 1'b1;
              started_d = 1'b1;
              opInfo_d = '{opcode: opcode_q, addr: addr_d};
              byteCnt_d = 2'h0;
              if (dummyCount(opcode_q) != DUMMY_NONE) begin
                state_d = ST_DUMMY;
              end else begin
                state_d = isRead(opcode_q) ? ST_DATAOUT : ST_DATAIN;
              end
            end
          end
        end
        ST_DUMMY: begin
          if (bitCnt_q == BIT_LAST) begin
            byteCnt_d = byteCnt_q + 2'h1;
            if (byteCnt_d == dummyCount(opcode_q)) begin
              state_d = ST_DATAOUT;
            end
          end
        end
        ST_DATAIN: begin
          if (bitCnt_q == BIT_LAST && takesData(opcode_q)) begin
            wrValid_d = 1'b1;
            wrByte_d = rxByte;
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      bitCnt_q <= 3'h0;
      byteCnt_q <= 2'h0;
      inShift_q <= 8'h00;
      opcode_q <= 8'h00;
      addr_q <= ADDR_ZERO;
      started_q <= 1'b0;
      opValid_q <= 1'b0;
      opInfo_q <= '0;
      opEnd_q <= 1'b0;
      opEndAligned_q <= 1'b0;
      wrValid_q <= 1'b0;
      wrByte_q <= 8'h00;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      byteCnt_q <= byteCnt_d;
      inShift_q <= inShift_d;
      opcode_q <= opcode_d;
      addr_q <= addr_d;
      started_q <= started_d;
      opValid_q <= opValid_d;
      opInfo_q <= opInfo_d;
      opEnd_q <= opEnd_d;
      opEndAligned_q <= opEndAligned_d;
      wrValid_q <= wrValid_d;
      wrByte_q <= wrByte_d;
    end
  end

  // ****************************************************
  // Read prefetch and buffer
  // ****************************************************
  logic [ADDR_W-1:0] readAddr_q, readAddr_d;
  logic fetchValid_q, fetchValid_d, fetchIssue, bufValid, bufPop, flush;
  logic [1:0] inflight_q, inflight_d, bufLevel;
  logic [2:0] credit;
  logic [7:0] bufData;
  op_info_t fetchReq_q, fetchReq_d;

  assign flush = (state_q != ST_DATAOUT);
  assign credit = {1'b0, bufLevel} + {1'b0, inflight_q} + {2'b0, fetchValid_q};
  assign fetchIssue = ~flush & (credit < 3'(BUF_DEPTH)) & (~fetchValid_q | fetchReady);

  two_entry_buffer #(.WIDTH(8)) u_buf (
    .mclk(mclk),
    .rstn(rstn),
    .flush(flush),
    .inValid(arrayValid),
    .inData(arrayData),
    .inReady(arrayReady),
    .outValid(bufValid),
    .outData(bufData),
    .outReady(bufPop),
    .level(bufLevel)
  );

  always_comb begin
    readAddr_d = readAddr_q;
    fetchValid_d = fetchValid_q & ~fetchReady;
    fetchReq_d = fetchReq_q;
    inflight_d = inflight_q + {1'b0, fetchValid_q & fetchReady}
      - {1'b0, arrayValid & arrayReady};
    if (flush) begin
      readAddr_d = addr_d;
      fetchValid_d = 1'b0;
      inflight_d = 2'h0;
    end else if (fetchIssue) begin
      // counter steps and wraps at the top
      fetchValid_d = 1'b1;
      fetchReq_d = '{opcode: opcode_q, addr: readAddr_q};
      readAddr_d = readAddr_q + 18'h00001;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readAddr_q <= ADDR_ZERO;
      fetchValid_q <= 1'b0;
      fetchReq_q <= '0;
      inflight_q <= 2'h0;
    end else begin
      readAddr_q <= readAddr_d;
      fetchValid_q <= fetchValid_d;
      fetchReq_q <= fetchReq_d;
      inflight_q <= inflight_d;
    end
  end

  // ****************************************************
  // Serial output shifter
  // ****************************************************
  logic [7:0] outShift_q, outShift_d, loadByte;
  logic [2:0] outBit_q, outBit_d;
  logic so_q, so_d, soOeN_q, soOeN_d;

  assign bufPop = sckFall & (state_q == ST_DATAOUT) & (outBit_q == 3'h0);
  assign loadByte = bufValid ? bufData : FILL_BYTE;

  always_comb begin
    outShift_d = outShift_q;
    outBit_d = outBit_q;
    so_d = so_q;
    soOeN_d = soOeN_q;
    if (state_q != ST_DATAOUT || csHigh) begin
      // release floats the output at any bit
      outBit_d = 3'h0;
      so_d = 1'b0;
      soOeN_d = 1'b1;
    end else if (sckFall) begin
      // drive on falling edge, MSB first
      soOeN_d = 1'b0;
      outBit_d = outBit_q + 3'h1;
      if (outBit_q == 3'h0) begin
        so_d = loadByte[7];
        outShift_d = {loadByte[6:0], 1'b0};
      end else begin
        so_d = outShift_q[7];
        outShift_d = {outShift_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      outShift_q <= 8'h00;
      outBit_q <= 3'h0;
      so_q <= 1'b0;
      soOeN_q <= 1'b1;
    end else begin
      outShift_q <= outShift_d;
      outBit_q <= outBit_d;
      so_q <= so_d;
      soOeN_q <= soOeN_d;
    end
  end

  assign soData = so_q;
  assign soOeN = soOeN_q;
  assign opValid = opValid_q;
  assign opInfo = opInfo_q;
  assign opEnd = opEnd_q;
  assign opEndAligned = opEndAligned_q;
  assign wrValid = wrValid_q;
  assign wrByte = wrByte_q;
  assign fetchValid = fetchValid_q;
  assign fetchReq = fetchReq_q;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_cs_idle: assert property (csHigh |=> state_q == ST_IDLE)
    else $error("release did not return to idle");
  a_unsup_noop: assert property (state_q == ST_IGNORE |=> !opValid_q && !wrValid_q)
    else $error("operation issued after unknown opcode");
  a_unsup_hold: assert property (state_q == ST_IGNORE && !csHigh |=> state_q == ST_IGNORE)
    else $error("left ignore state without release");
  a_early_abort: assert property ((state_q == ST_ADDR || state_q == ST_OPCODE) && csHigh
    |=> !opValid_q && !opEnd_q)
    else $error("partial header produced an operation");
  a_addr_step: assert property (fetchIssue |=> readAddr_q == $past(readAddr_q) + 18'h00001)
    else $error("read address did not step");
  a_addr_wrap: assert property (fetchIssue && readAddr_q == ADDR_TOP
    |=> fetchReq_q.addr == ADDR_TOP ##0 readAddr_q == ADDR_ZERO)
    else $error("read address did not wrap to zero");
  a_msb_out: assert property (sckFall && state_q == ST_DATAOUT && outBit_q != 3'h0 && !csHigh
    |=> so_q == $past(outShift_q[7]) && !soOeN_q)
    else $error("output bit not taken from shifter top");
  a_hiz_release: assert property (csHigh |=> soOeN_q ##1 soOeN_q || !csHigh)
    else $error("output still driven after release");
  a_fetch_hold: assert property (fetchValid_q && !fetchReady && !flush
    |=> fetchValid_q && $stable(fetchReq_q))
    else $error("fetch request changed before it was taken");
  a_addr_bits: assert property (opValid_q && needsAddr(opInfo_q.opcode)
    |-> opInfo_q.addr == addr_q)
    else $error("issued address differs from collected bits");

  c_fast_read: cover property (state_q == ST_DUMMY ##[1:400] state_q == ST_DATAOUT);
  c_wrap: cover property (fetchIssue && readAddr_q == ADDR_TOP);
  c_unsup: cover property (state_q == ST_IGNORE ##[1:400] state_q == ST_IDLE);
  c_prog_byte: cover property (wrValid_q && opcode_q == OP_PROGRAM);
endmodule
`default_nettype wire

/* File: verif/spi_host_model.sv */
// Serial bus master model driving chip select, clock and data in
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic csN,
  output logic sck,
  output logic si,
  input wire logic soData,
  input wire logic soOeN
);
  logic idleHigh;
  // ************************************************
  // Pin state outside frames
  // ************************************************
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    idleHigh = 1'b0;
  end
  // ************************************************
  // Frame tasks
  // ************************************************
  // select with clock parked at idle level
  task automatic open_frame(input logic mode3);
    idleHigh = mode3;
    sck <= mode3;
    #62.5;
    csN <= 1'b0;
    #62.5;
  endtask
  // MSB first, 8 MHz, change on fall, sample on rise
  task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      sck <= 1'b0;
      si <= tx[7-i];
      #62.5;
      sck <= 1'b1;
      rx[7-i] = soData;
      #62.5;
    end
  endtask
  // release ends the frame, clock stands, data line inverted
  task automatic close_frame();
    sck <= idleHigh;
    #62.5;
    csN <= 1'b1;
    si <= ~si;
    #250;
  endtask
endmodule
`default_nettype wire

/* File: verif/serial_flash_cmd_front_end_tb.sv */
// Self-checking bench for the serial flash command front end
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_front_end_tb;
  import flash_cmd_pkg::*;
  typedef struct {logic [7:0] op; int nAddr; int nDum; logic ok;} row_t;
  logic mclk;
  logic rstn;
  wire csN;
  wire sck;
  wire si;
  logic soData, soOeN, opValid, opEnd, opEndAligned, wrValid, fetchValid, arrayReady;
  op_info_t opInfo, fetchReq, lastInfo;
  logic [7:0] wrByte, rx;
  logic fetchReady;
  logic arrayValid;
  logic [7:0] arrayData;
  logic lastAligned;
  logic [7:0] wrQ[$];
  logic [17:0] pend[$];
  int mismatches, check_count, opCnt, endCnt, fetchCnt, oeCnt, lag, served, wcnt, o, e, f, g;
  row_t rows[21] = '{'{8'h0B, 3, 1, 1}, '{8'h03, 3, 0, 1}, '{8'h20, 3, 0, 1},
    '{8'h52, 3, 0, 1}, '{8'hD8, 3, 0, 1}, '{8'h60, 0, 0, 1}, '{8'hC7, 0, 0, 1},
    '{8'h02, 3, 0, 1}, '{8'h06, 0, 0, 1}, '{8'h04, 0, 0, 1}, '{8'h36, 3, 0, 1},
    '{8'h39, 3, 0, 1}, '{8'h3C, 3, 0, 1}, '{8'h9B, 3, 0, 1}, '{8'h77, 3, 2, 1},
    '{8'h05, 0, 0, 1}, '{8'h01, 0, 0, 1}, '{8'h9F, 0, 0, 1}, '{8'hB9, 0, 0, 1},
    '{8'hAB, 0, 0, 1}, '{8'h5A, 0, 0, 0}};

  serial_flash_cmd_front_end dut (.mclk(mclk), .rstn(rstn), .csN(csN), .sck(sck), .si(si),
    .soData(soData), .soOeN(soOeN), .opValid(opValid), .opInfo(opInfo), .opEnd(opEnd),
    .opEndAligned(opEndAligned), .wrValid(wrValid), .wrByte(wrByte),
    .fetchValid(fetchValid), .fetchReq(fetchReq), .fetchReady(fetchReady),
    .arrayValid(arrayValid), .arrayData(arrayData), .arrayReady(arrayReady));
  spi_host_model host (.csN(csN), .sck(sck), .si(si), .soData(soData), .soOeN(soOeN));

  // ************************************************
  // Clock, array responder and monitors
  // ************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [7:0] pat(input logic [17:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  always @(posedge mclk) begin
    if (fetchValid === 1'b1 && fetchReady) begin
      pend.push_back(fetchReq.addr);
      fetchCnt++;
    end
    fetchReady <= (fetchValid === 1'b1) && !fetchReady;
    if (csN || !rstn) begin
      pend.delete();
      arrayValid <= 1'b0;
      arrayData <= 8'h00;
      served = 0;
      wcnt = 0;
    end else if (arrayValid) begin
      if (arrayReady === 1'b1) begin
        arrayValid <= 1'b0;
        served++;
      end
    end else if (pend.size() > 0) begin
      if (wcnt >= (served > 0 ? lag : 0)) begin
        arrayValid <= 1'b1;
        arrayData <= pat(pend.pop_front());
        wcnt = 0;
      end else wcnt++;
    end
    if (opValid === 1'b1) begin
      opCnt++;
      lastInfo = opInfo;
    end
    if (opEnd === 1'b1) begin
      endCnt++;
      lastAligned = opEndAligned;
    end
    if (wrValid === 1'b1) wrQ.push_back(wrByte);
    if (soOeN === 1'b0) oeCnt++;
  end

  // ************************************************
  // Compare and closing tasks
  // ************************************************
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    chkByte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic chkInfo(input op_info_t got, input op_info_t exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #500us;
    mismatches++;
    finish_test();
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    rstn = 1'b0;
    lag = 0;
    repeat (4) @(posedge mclk);
    chkBit(soOeN, 1'b1);
    chkBit(fetchValid, 1'b0);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    for (int r = 0; r < 21; r++) begin
      o = opCnt;
      e = endCnt;
      host.open_frame(1'b0);
      host.shift(rows[r].op, 8, rx);
      for (int b = 0; b < rows[r].nAddr + rows[r].nDum; b++)
        host.shift(b == 0 ? 8'hFC : (b == 1 ? 8'h12 : 8'h34), 8, rx);
      host.close_frame();
      chkByte(8'(opCnt - o), {7'h00, rows[r].ok});
      chkByte(8'(endCnt - e), {7'h00, rows[r].ok});
      if (rows[r].ok) chkByte(lastInfo.opcode, rows[r].op);
      if (rows[r].ok) chkBit(lastAligned, 1'b1);
      if (rows[r].ok && rows[r].nAddr > 0) chkInfo(lastInfo, {rows[r].op, 18'h01234});
    end
    // Wrapping read from the top of the array, released mid-byte
    host.open_frame(1'b0);
    host.shift(8'h03, 8, rx);
    host.shift(8'hFF, 8, rx);
    host.shift(8'hFF, 8, rx);
    host.shift(8'hFE, 8, rx);
    for (int k = 0; k < 3; k++) begin
      host.shift(8'h00, 8, rx);
      chkByte(rx, pat(18'h3FFFE + 18'(k)));
    end
    chkBit(soOeN, 1'b0);
    host.shift(8'h00, 3, rx);
    chkByte({rx[7:5], 5'h00}, 8'h40);
    host.close_frame();
    chkBit(soOeN, 1'b1);
    // Mode 3 dummy-byte read with a slow array
    lag = 40;
    host.open_frame(1'b1);
    host.shift(8'h0B, 8, rx);
    host.shift(8'h00, 8, rx);
    host.shift(8'h00, 8, rx);
    host.shift(8'h10, 8, rx);
    host.shift(8'hA5, 8, rx);
    for (int k = 0; k < 3; k++) begin
      host.shift(8'h00, 8, rx);
      chkByte(rx, pat(18'h00010 + 18'(k)));
    end
    host.close_frame();
    chkBit(soOeN, 1'b1);
    lag = 0;
    // Unsupported opcode followed by a read-like stream
    o = opCnt;
    f = fetchCnt;
    g = oeCnt;
    host.open_frame(1'b0);
    host.shift(8'h5A, 8, rx);
    for (int k = 0; k < 5; k++) host.shift(8'h03, 8, rx);
    host.close_frame();
    chkByte(8'(opCnt - o), 8'h00);
    chkByte(8'(fetchCnt - f), 8'h00);
    chkByte(8'(oeCnt - g), 8'h00);
    // Release during the address bytes
    o = opCnt;
    e = endCnt;
    host.open_frame(1'b0);
    host.shift(8'h20, 8, rx);
    host.shift(8'hFC, 8, rx);
    host.close_frame();
    chkByte(8'(opCnt - o), 8'h00);
    chkByte(8'(endCnt - e), 8'h00);
    // Program with two whole bytes and a partial one
    wrQ.delete();
    host.open_frame(1'b0);
    host.shift(8'h02, 8, rx);
    host.shift(8'h00, 8, rx);
    host.shift(8'h01, 8, rx);
    host.shift(8'h00, 8, rx);
    host.shift(8'h3C, 8, rx);
    host.shift(8'hC3, 8, rx);
    host.shift(8'hFF, 3, rx);
    host.close_frame();
    chkInfo(lastInfo, {8'h02, 18'h00100});
    chkByte(8'(wrQ.size()), 8'h02);
    chkByte(wrQ[0], 8'h3C);
    chkByte(wrQ[1], 8'hC3);
    chkBit(lastAligned, 1'b0);
    // Reset in the middle of a read stream
    host.open_frame(1'b0);
    host.shift(8'h03, 8, rx);
    for (int k = 0; k < 4; k++) host.shift(8'h00, 8, rx);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    chkBit(soOeN, 1'b1);
    chkBit(fetchValid, 1'b0);
    host.close_frame();
    @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    o = opCnt;
    e = endCnt;
    host.open_frame(1'b0);
    host.shift(8'h06, 8, rx);
    host.close_frame();
    chkByte(8'(opCnt - o), 8'h01);
    chkByte(8'(endCnt - e), 8'h01);
    finish_test();
  end
endmodule
`default_nettype wire
